// ===== design/acmp_delay_timer.sv
// millisecond delay timer: restarts on demand, flags when the limit is passed
`timescale 1ns/1ps
module acmp_delay_timer (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic restart,
  input wire logic ms_stb,
  input wire logic [acmp_pkg::DLY_W-1:0] limit,
  // status
  output logic done
);

  logic [acmp_pkg::DLY_W:0] cnt_ff;
  logic [acmp_pkg::DLY_W:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // counter saturates, so a long wait never wraps back below the limit
  always_comb begin
    nxt_cnt = cnt_ff;
    if (restart) begin
      nxt_cnt = '0;
    end else if (ms_stb && (cnt_ff != '1)) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    // the first strobe may follow a restart at once, so the limit must be passed, not met
    nxt_done = !restart && ((limit == '0) || (nxt_cnt > {1'b0, limit}));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

// ===== design/acmp_limit_comparator.sv
// analog limit comparator: operating signal, pickup with hysteresis, delayed operate
// Operation
// - operating signal is plus input minus minus input; an off input counts as zero
// - with no input selected, pickup and operate are never asserted; config_fault is set
// - inputs of different quantity types stop operation, keep pickup and operate low and set config_fault
// - signed mode uses the difference signal with its sign
// - absolute mode uses the magnitude of the difference signal
// - level mode compares the operating signal itself with the pickup level
// - delta mode compares the change over the configured interval with pickup
// - interval length and unit only matter in delta mode
// - over sense picks up when the compared signal exceeds pickup
// - under sense picks up when the compared signal falls below pickup
// - dropout needs a return past pickup by a percentage hysteresis band
// - signal and pickup level are signed, negatives compare correctly
// - pickup is per-unit; frequency base 1 hz, angle base 360 degrees
// - energy pickup base is 10000 mwh or 10000 mvah
// - harmonic and distortion pickup base is 100 percent of fundamental
// - source current and voltage base is the larger nominal of both inputs
// - transducer base is the larger configured range of both transducers
// - operate sets after pickup delay and clears after reset delay
`timescale 1ns/1ps
module acmp_limit_comparator #(
  parameter int CYC_PER_MS = acmp_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // measurement engine
  input wire logic tick,
  input wire logic signed [acmp_pkg::SIG_W-1:0] plus_value,
  input wire logic signed [acmp_pkg::SIG_W-1:0] minus_value,
  input wire acmp_pkg::acmp_qty_e plus_type,
  input wire acmp_pkg::acmp_qty_e minus_type,
  input wire logic [acmp_pkg::BASE_W-1:0] plus_base,
  input wire logic [acmp_pkg::BASE_W-1:0] minus_base,
  // settings
  input wire logic plus_input_select,
  input wire logic minus_input_select,
  input wire acmp_pkg::acmp_sign_e sign_handling_select,
  input wire acmp_pkg::acmp_kind_e compare_kind_select,
  input wire acmp_pkg::acmp_sense_e compare_sense,
  input wire logic signed [acmp_pkg::THR_W-1:0] operate_threshold,
  input wire logic [acmp_pkg::PCT_W-1:0] dropout_band_pct,
  input wire acmp_pkg::acmp_unit_e rate_interval_unit,
  input wire logic [acmp_pkg::DLY_W-1:0] rate_interval_length,
  input wire logic [acmp_pkg::DLY_W-1:0] operate_delay,
  input wire logic [acmp_pkg::DLY_W-1:0] release_delay,
  // logic operands
  output logic pickup,
  output logic operate,
  output logic dropout,
  output logic config_fault
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  acmp_pkg::acmp_wide_t plus_w;
  acmp_pkg::acmp_wide_t minus_w;
  acmp_pkg::acmp_wide_t diff_w;
  acmp_pkg::acmp_wide_t sel_w;
  acmp_pkg::acmp_wide_t cmp_w;
  acmp_pkg::acmp_wide_t pk_w;
  acmp_pkg::acmp_wide_t pk_mag;
  acmp_pkg::acmp_wide_t band_w;
  acmp_pkg::acmp_wide_t lo_w;
  acmp_pkg::acmp_wide_t hi_w;
  logic signed [48:0] pk_prod;
  logic [45:0] band_prod;
  logic [acmp_pkg::BASE_W-1:0] pb_w;
  logic [acmp_pkg::BASE_W-1:0] mb_w;
  logic [acmp_pkg::BASE_W-1:0] base_w;
  acmp_pkg::acmp_qty_e qty_w;
  logic valid_w;

  acmp_pkg::acmp_div_t div_ff;
  acmp_pkg::acmp_div_t nxt_div;
  logic ms_stb_ff;
  logic nxt_ms_stb;
  logic [acmp_pkg::UNIT_W-1:0] unit_cnt_ff;
  logic [acmp_pkg::UNIT_W-1:0] nxt_unit_cnt;
  logic [acmp_pkg::UNIT_W-1:0] unit_len;
  logic [acmp_pkg::DLY_W-1:0] int_cnt_ff;
  logic [acmp_pkg::DLY_W-1:0] nxt_int_cnt;
  acmp_pkg::acmp_wide_t ref_ff;
  acmp_pkg::acmp_wide_t nxt_ref;
  acmp_pkg::acmp_wide_t delta_ff;
  acmp_pkg::acmp_wide_t nxt_delta;
  logic primed_ff;
  logic nxt_primed;

  logic pickup_ff;
  logic nxt_pickup;
  acmp_pkg::acmp_state_e state_ff;
  acmp_pkg::acmp_state_e nxt_state;
  logic operate_ff;
  logic nxt_operate;
  logic dropout_ff;
  logic fault_ff;
  logic timer_done;
  logic [acmp_pkg::DLY_W-1:0] timer_limit;

  // ----------------------------------------------------------------
  // operating signal and pickup level
  // ----------------------------------------------------------------
  always_comb begin
    plus_w = plus_input_select ? acmp_pkg::acmp_wide_t'(plus_value) : '0;
    minus_w = minus_input_select ? acmp_pkg::acmp_wide_t'(minus_value) : '0;
    diff_w = plus_w - minus_w;
    valid_w = (plus_input_select || minus_input_select) &&
              !(plus_input_select && minus_input_select && (plus_type != minus_type));
    qty_w = plus_input_select ? plus_type : minus_type;
    pb_w = plus_input_select ? plus_base : '0;
    mb_w = minus_input_select ? minus_base : '0;
    case (qty_w)
      acmp_pkg::QTY_FREQ: base_w = acmp_pkg::BASE_FREQ;
      acmp_pkg::QTY_ANGLE: base_w = acmp_pkg::BASE_ANGLE;
      acmp_pkg::QTY_WATTH, acmp_pkg::QTY_VARH: base_w = acmp_pkg::BASE_ENERGY;
      acmp_pkg::QTY_HARMONIC: base_w = acmp_pkg::BASE_HARM;
      default: base_w = (pb_w >= mb_w) ? pb_w : mb_w;
    endcase
    // signed product keeps negative thresholds negative
    pk_prod = $signed(operate_threshold) * $signed({1'b0, base_w});
    pk_w = acmp_pkg::acmp_wide_t'(pk_prod >>> acmp_pkg::THR_FRAC);
    pk_mag = pk_w[acmp_pkg::WIDE_W-1] ? -pk_w : pk_w;
    band_prod = 46'(pk_mag) * 46'(dropout_band_pct);
    band_w = acmp_pkg::acmp_wide_t'(band_prod / 46'(acmp_pkg::PCT_FULL));
    lo_w = pk_w - band_w;
    hi_w = pk_w + band_w;
    sel_w = (compare_kind_select == acmp_pkg::CMP_DELTA) ? delta_ff : diff_w;
    // internal width leaves headroom, so negation never overflows
    if ((sign_handling_select == acmp_pkg::SIGN_ABS) && sel_w[acmp_pkg::WIDE_W-1]) begin
      cmp_w = -sel_w;
    end else begin
      cmp_w = sel_w;
    end
  end

  // ----------------------------------------------------------------
  // rate interval: ms divider, unit counter, interval counter
  // ----------------------------------------------------------------
  always_comb begin
    case (rate_interval_unit)
      acmp_pkg::UNIT_S: unit_len = acmp_pkg::MS_PER_S;
      acmp_pkg::UNIT_MIN: unit_len = acmp_pkg::MS_PER_MIN;
      default: unit_len = acmp_pkg::MS_PER_MS;
    endcase
    nxt_ms_stb = 1'b0;
    nxt_div = div_ff + 1'b1;
    if (div_ff == acmp_pkg::acmp_div_t'(CYC_PER_MS - 1)) begin
      nxt_div = '0;
      nxt_ms_stb = 1'b1;
    end
    nxt_unit_cnt = unit_cnt_ff;
    nxt_int_cnt = int_cnt_ff;
    nxt_ref = ref_ff;
    nxt_delta = delta_ff;
    nxt_primed = primed_ff;
    if (compare_kind_select != acmp_pkg::CMP_DELTA) begin
      // level mode holds the rate path idle
      nxt_unit_cnt = '0;
      nxt_int_cnt = '0;
      nxt_primed = 1'b0;
      nxt_delta = '0;
    end else if (ms_stb_ff) begin
      nxt_unit_cnt = unit_cnt_ff + 1'b1;
      if (nxt_unit_cnt >= unit_len) begin
        nxt_unit_cnt = '0;
        nxt_int_cnt = int_cnt_ff + 1'b1;
        // a zero length behaves as one unit
        if (nxt_int_cnt >= rate_interval_length) begin
          nxt_int_cnt = '0;
          nxt_ref = diff_w;
          nxt_delta = primed_ff ? (diff_w - ref_ff) : '0;
          nxt_primed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= '0;
      ms_stb_ff <= 1'b0;
      unit_cnt_ff <= '0;
      int_cnt_ff <= '0;
      ref_ff <= '0;
      delta_ff <= '0;
      primed_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      ms_stb_ff <= nxt_ms_stb;
      unit_cnt_ff <= nxt_unit_cnt;
      int_cnt_ff <= nxt_int_cnt;
      ref_ff <= nxt_ref;
      delta_ff <= nxt_delta;
      primed_ff <= nxt_primed;
    end
  end

  // ----------------------------------------------------------------
  // pickup with hysteresis
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pickup = pickup_ff;
    if (!valid_w) begin
      nxt_pickup = 1'b0;
    end else if (tick) begin
      if (compare_sense == acmp_pkg::SENSE_OVER) begin
        nxt_pickup = pickup_ff ? (cmp_w >= lo_w) : (cmp_w > pk_w);
      end else begin
        nxt_pickup = pickup_ff ? (cmp_w <= hi_w) : (cmp_w < pk_w);
      end
    end
  end

  // ----------------------------------------------------------------
  // operate sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      acmp_pkg::ST_IDLE: begin
        if (pickup_ff) begin
          nxt_state = acmp_pkg::ST_ARMING;
        end
      end
      acmp_pkg::ST_ARMING: begin
        if (!pickup_ff) begin
          nxt_state = acmp_pkg::ST_IDLE;
        end else if (timer_done) begin
          nxt_state = acmp_pkg::ST_OPERATE;
        end
      end
      acmp_pkg::ST_OPERATE: begin
        if (!pickup_ff) begin
          nxt_state = acmp_pkg::ST_RELEASING;
        end
      end
      acmp_pkg::ST_RELEASING: begin
        if (pickup_ff) begin
          nxt_state = acmp_pkg::ST_OPERATE;
        end else if (timer_done) begin
          nxt_state = acmp_pkg::ST_IDLE;
        end
      end
      default: nxt_state = acmp_pkg::ST_IDLE;
    endcase
    // an invalid input pair drops everything at once, no reset delay
    if (!valid_w) begin
      nxt_state = acmp_pkg::ST_IDLE;
    end
    nxt_operate = (nxt_state == acmp_pkg::ST_OPERATE) ||
                  (nxt_state == acmp_pkg::ST_RELEASING);
    timer_limit = (state_ff == acmp_pkg::ST_ARMING) ? operate_delay : release_delay;
  end

  acmp_delay_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .restart(state_ff != nxt_state),
    .ms_stb(ms_stb_ff),
    .limit(timer_limit),
    .done(timer_done)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pickup_ff <= 1'b0;
      state_ff <= acmp_pkg::ST_IDLE;
      operate_ff <= 1'b0;
      dropout_ff <= 1'b1;
      fault_ff <= 1'b0;
    end else begin
      pickup_ff <= nxt_pickup;
      state_ff <= nxt_state;
      operate_ff <= nxt_operate;
      dropout_ff <= !nxt_operate;
      fault_ff <= !valid_w;
    end
  end

  assign pickup = pickup_ff;
  assign operate = operate_ff;
  assign dropout = dropout_ff;
  assign config_fault = fault_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_none_selected: assert property (@(posedge clk) disable iff (!reset_n)
    (!plus_input_select && !minus_input_select) |=> (!pickup_ff && !operate_ff))
    else $error("output asserted with no input selected");

  a_type_mismatch: assert property (@(posedge clk) disable iff (!reset_n)
    (plus_input_select && minus_input_select && (plus_type != minus_type))
    |=> (!pickup_ff && !operate_ff && fault_ff))
    else $error("comparator active on mismatched quantity types");

  a_diff_form: assert property (@(posedge clk) disable iff (!reset_n)
    (plus_input_select && !minus_input_select)
    |-> (diff_w == acmp_pkg::acmp_wide_t'(plus_value)))
    else $error("deselected input not taken as zero");

  a_signed_level: assert property (@(posedge clk) disable iff (!reset_n)
    ((sign_handling_select == acmp_pkg::SIGN_KEEP) &&
     (compare_kind_select == acmp_pkg::CMP_LEVEL)) |-> (cmp_w == diff_w))
    else $error("signed level mode does not use the difference directly");

  a_abs_mag: assert property (@(posedge clk) disable iff (!reset_n)
    (sign_handling_select == acmp_pkg::SIGN_ABS) |-> !cmp_w[acmp_pkg::WIDE_W-1])
    else $error("absolute mode produced a negative value");

  a_delta_source: assert property (@(posedge clk) disable iff (!reset_n)
    ((sign_handling_select == acmp_pkg::SIGN_KEEP) &&
     (compare_kind_select == acmp_pkg::CMP_DELTA)) |-> (cmp_w == delta_ff))
    else $error("delta mode does not compare the rate value");

  a_level_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (compare_kind_select == acmp_pkg::CMP_LEVEL) |=> ((int_cnt_ff == '0) && !primed_ff))
    else $error("rate interval runs in level mode");

  a_over_pickup: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && valid_w && (compare_sense == acmp_pkg::SENSE_OVER) && !pickup_ff &&
     (cmp_w > pk_w)) |=> pickup_ff)
    else $error("no pickup on over sense");

  a_under_pickup: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && valid_w && (compare_sense == acmp_pkg::SENSE_UNDER) && !pickup_ff &&
     (cmp_w < pk_w)) |=> pickup_ff)
    else $error("no pickup on under sense");

  a_band_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && valid_w && (compare_sense == acmp_pkg::SENSE_OVER) && pickup_ff &&
     (cmp_w >= lo_w)) |=> pickup_ff)
    else $error("dropout inside the hysteresis band");

  a_band_drop: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && valid_w && (compare_sense == acmp_pkg::SENSE_UNDER) && pickup_ff &&
     (cmp_w > hi_w)) |=> !pickup_ff)
    else $error("no dropout beyond the hysteresis band");

  a_hold_between: assert property (@(posedge clk) disable iff (!reset_n)
    (valid_w && !tick) |=> (pickup_ff == $past(pickup_ff)))
    else $error("pickup changed without a tick");

  a_operate_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(operate_ff) |-> ($past(pickup_ff) && ($past(state_ff) == acmp_pkg::ST_ARMING)))
    else $error("operate set without a timed pickup");

  a_release_cause: assert property (@(posedge clk) disable iff (!reset_n)
    ($fell(operate_ff) && $past(valid_w))
    |-> (!$past(pickup_ff) && ($past(state_ff) == acmp_pkg::ST_RELEASING)))
    else $error("operate cleared without a timed dropout");

endmodule

// ===== design/acmp_pkg.sv
// package: constants and types of the analog limit comparator
package acmp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SIG_W = 32;
  localparam int WIDE_W = 36;
  localparam int THR_W = 24;
  localparam int THR_FRAC = 12;
  localparam int BASE_W = 24;
  localparam int PCT_W = 10;
  localparam int DLY_W = 16;
  localparam int UNIT_W = 17;
  localparam int DIV_W = 18;

  // ----------------------------------------------------------------
  // scaling: hysteresis in 0.1 %, threshold in 1/4096 per-unit
  // ----------------------------------------------------------------
  localparam int PCT_FULL = 1000;
  // per-unit bases expressed in input lsb units
  localparam logic [BASE_W-1:0] BASE_FREQ = 24'h0003e8;   // 1 hz in mhz
  localparam logic [BASE_W-1:0] BASE_ANGLE = 24'h008ca0;  // 360 deg in 0.01 deg
  localparam logic [BASE_W-1:0] BASE_ENERGY = 24'h002710; // 10000 mwh or mvah
  localparam logic [BASE_W-1:0] BASE_HARM = 24'h002710;   // 100 % in 0.01 %

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int CYC_PER_MS = MS_PS / CLK_PERIOD_PS;
  localparam logic [UNIT_W-1:0] MS_PER_MS = 17'h00001;
  localparam logic [UNIT_W-1:0] MS_PER_S = 17'h003e8;
  localparam logic [UNIT_W-1:0] MS_PER_MIN = 17'h0ea60;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic signed [WIDE_W-1:0] acmp_wide_t;
  typedef logic [DIV_W-1:0] acmp_div_t;

  typedef enum logic [3:0] {
    QTY_CURRENT = 4'h0,
    QTY_VOLTAGE = 4'h1,
    QTY_TRANSDUCER = 4'h2,
    QTY_FREQ = 4'h3,
    QTY_ANGLE = 4'h4,
    QTY_WATTH = 4'h5,
    QTY_VARH = 4'h6,
    QTY_HARMONIC = 4'h7,
    QTY_OTHER = 4'h8
  } acmp_qty_e;

  typedef enum logic {SIGN_KEEP = 1'b0, SIGN_ABS = 1'b1} acmp_sign_e;
  typedef enum logic {CMP_LEVEL = 1'b0, CMP_DELTA = 1'b1} acmp_kind_e;
  typedef enum logic {SENSE_OVER = 1'b0, SENSE_UNDER = 1'b1} acmp_sense_e;

  typedef enum logic [1:0] {
    UNIT_MS = 2'h0,
    UNIT_S = 2'h1,
    UNIT_MIN = 2'h2
  } acmp_unit_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMING = 2'h1,
    ST_OPERATE = 2'h2,
    ST_RELEASING = 2'h3
  } acmp_state_e;

endpackage

// ===== dv/acmp_meas_model.sv
// measurement engine model: periodic evaluation tick and published sample values
`timescale 1ns/1ps
module acmp_meas_model #(
  parameter int TICK_GAP = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // samples requested by the bench
  input wire logic signed [acmp_pkg::SIG_W-1:0] new_plus,
  input wire logic signed [acmp_pkg::SIG_W-1:0] new_minus,
  // towards the comparator
  output logic tick,
  output logic signed [acmp_pkg::SIG_W-1:0] plus_value,
  output logic signed [acmp_pkg::SIG_W-1:0] minus_value
);
  // ----------------------------------------------------------------
  // tick pacing
  // ----------------------------------------------------------------
  int gap_cnt;
  // samples move together with the tick, so no half-updated pair is ever evaluated
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt <= 0;
      tick <= 1'b0;
      plus_value <= '0;
      minus_value <= '0;
    end else begin
      tick <= (gap_cnt == TICK_GAP - 1);
      gap_cnt <= (gap_cnt == TICK_GAP - 1) ? 0 : gap_cnt + 1;
      if (gap_cnt == TICK_GAP - 1) begin
        plus_value <= new_plus;
        minus_value <= new_minus;
      end
    end
  end
endmodule

// ===== dv/testbench.sv
// self-checking bench of the analog limit comparator
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t ns: mismatch at line %0d", $time, `__LINE__); end end
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, reset_n, tick, pickup, operate, dropout, config_fault;
  logic plus_input_select, minus_input_select;
  logic signed [acmp_pkg::SIG_W-1:0] new_plus, new_minus, plus_value, minus_value;
  acmp_pkg::acmp_qty_e plus_type, minus_type;
  logic [acmp_pkg::BASE_W-1:0] plus_base, minus_base;
  acmp_pkg::acmp_sign_e sign_handling_select;
  acmp_pkg::acmp_kind_e compare_kind_select;
  acmp_pkg::acmp_sense_e compare_sense;
  logic signed [acmp_pkg::THR_W-1:0] operate_threshold;
  logic [acmp_pkg::PCT_W-1:0] dropout_band_pct;
  acmp_pkg::acmp_unit_e rate_interval_unit;
  logic [acmp_pkg::DLY_W-1:0] rate_interval_length, operate_delay, release_delay;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  acmp_meas_model #(.TICK_GAP(3)) i_acmp_meas_model (.clk(clk), .reset_n(reset_n),
    .new_plus(new_plus), .new_minus(new_minus), .tick(tick),
    .plus_value(plus_value), .minus_value(minus_value));

  // short ms of 4 cycles, so that delays of a few ms stay about a dozen cycles
  acmp_limit_comparator #(.CYC_PER_MS(4)) i_acmp_limit_comparator (.clk(clk),
    .reset_n(reset_n), .tick(tick), .plus_value(plus_value), .minus_value(minus_value),
    .plus_type(plus_type), .minus_type(minus_type), .plus_base(plus_base),
    .minus_base(minus_base), .plus_input_select(plus_input_select),
    .minus_input_select(minus_input_select), .sign_handling_select(sign_handling_select),
    .compare_kind_select(compare_kind_select), .compare_sense(compare_sense),
    .operate_threshold(operate_threshold), .dropout_band_pct(dropout_band_pct),
    .rate_interval_unit(rate_interval_unit), .rate_interval_length(rate_interval_length),
    .operate_delay(operate_delay), .release_delay(release_delay), .pickup(pickup),
    .operate(operate), .dropout(dropout), .config_fault(config_fault));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // waits for pickup (sel 0) or operate (sel 1) to reach lvl; n is the cycle count
  task automatic wait_lvl(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    while ((sel ? operate : pickup) !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // plain level setup; the wild interval settings must not matter outside delta mode
  task automatic setup(input acmp_pkg::acmp_qty_e q, input logic signed [23:0] thr);
    @(negedge clk);
    plus_type = q;
    minus_type = q;
    plus_input_select = 1'b1;
    minus_input_select = 1'b0;
    sign_handling_select = acmp_pkg::SIGN_KEEP;
    compare_kind_select = acmp_pkg::CMP_LEVEL;
    compare_sense = acmp_pkg::SENSE_OVER;
    operate_threshold = thr;
    dropout_band_pct = '0;
    rate_interval_unit = acmp_pkg::UNIT_MIN;
    rate_interval_length = 16'hffff;
    operate_delay = '0;
    release_delay = '0;
    new_plus = '0;
    new_minus = '0;
    step(12);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_mid();
    setup(acmp_pkg::QTY_FREQ, 24'sh001000);
    new_plus = 32'sh00001388;
    step(20);
    `CHK(operate, 1'b1)
    reset_n = 1'b0;
    step(1);
    `CHK({pickup, operate, dropout, config_fault}, 4'h2)
    reset_n = 1'b1;
    step(12);
    `CHK({pickup, config_fault}, 2'h2)
  endtask

  task automatic t_select();
    setup(acmp_pkg::QTY_FREQ, 24'sh001000);
    plus_input_select = 1'b0;
    // under sense would pick up on the zero signal if the selection gate failed
    compare_sense = acmp_pkg::SENSE_UNDER;
    new_plus = 32'sh00001388;
    step(12);
    `CHK({config_fault, pickup, operate}, 3'h4)
    compare_sense = acmp_pkg::SENSE_OVER;
    plus_input_select = 1'b1;
    minus_input_select = 1'b1;
    minus_type = acmp_pkg::QTY_ANGLE;
    step(12);
    `CHK({config_fault, pickup, operate}, 3'h4)
    minus_type = acmp_pkg::QTY_FREQ;
    new_minus = 32'sh00001194;
    step(12);
    `CHK({config_fault, pickup}, 2'h0)
  endtask

  task automatic t_delays();
    int n;
    setup(acmp_pkg::QTY_FREQ, 24'sh001000);
    dropout_band_pct = 10'h064;
    operate_delay = 16'h0002;
    release_delay = 16'h0001;
    new_plus = 32'sh000003e9;
    wait_lvl(0, 1'b1, 12, n);
    `CHK(n < 12, 1'b1)
    wait_lvl(1, 1'b1, 24, n);
    `CHK(n >= 8 && n <= 16, 1'b1)
    `CHK(dropout, 1'b0)
    new_plus = 32'sh000003b6;
    step(12);
    `CHK(pickup, 1'b1)
    new_plus = 32'sh00000383;
    wait_lvl(0, 1'b0, 12, n);
    `CHK(n < 12, 1'b1)
    wait_lvl(1, 1'b0, 16, n);
    `CHK(n >= 4 && n <= 12, 1'b1)
    `CHK(dropout, 1'b1)
  endtask

  task automatic t_signs();
    setup(acmp_pkg::QTY_FREQ, 24'shfff000);
    plus_input_select = 1'b0;
    minus_input_select = 1'b1;
    compare_sense = acmp_pkg::SENSE_UNDER;
    new_minus = 32'sh000003e9;
    step(12);
    `CHK(pickup, 1'b1)
    compare_sense = acmp_pkg::SENSE_OVER;
    step(12);
    `CHK(pickup, 1'b0)
    operate_threshold = 24'sh001000;
    sign_handling_select = acmp_pkg::SIGN_ABS;
    step(12);
    `CHK(pickup, 1'b1)
    sign_handling_select = acmp_pkg::SIGN_KEEP;
    step(12);
    `CHK(pickup, 1'b0)
  endtask

  task automatic t_bases();
    acmp_pkg::acmp_qty_e qs[8] = '{acmp_pkg::QTY_FREQ, acmp_pkg::QTY_ANGLE,
      acmp_pkg::QTY_WATTH, acmp_pkg::QTY_VARH, acmp_pkg::QTY_HARMONIC,
      acmp_pkg::QTY_CURRENT, acmp_pkg::QTY_VOLTAGE, acmp_pkg::QTY_TRANSDUCER};
    int bs[8] = '{1000, 36000, 10000, 10000, 10000, 800, 800, 800};
    for (int i = 0; i < 8; i++) begin
      setup(qs[i], 24'sh001000);
      minus_input_select = 1'b1;
      plus_base = 24'h0001f4;
      minus_base = 24'h000320;
      new_plus = bs[i] + 1;
      step(12);
      `CHK(pickup, 1'b1)
      new_plus = bs[i] - 1;
      step(12);
      `CHK(pickup, 1'b0)
    end
  endtask

  task automatic t_delta();
    int n;
    setup(acmp_pkg::QTY_FREQ, 24'sh001000);
    new_plus = 32'sh00000bb8;
    step(12);
    `CHK(pickup, 1'b1)
    compare_kind_select = acmp_pkg::CMP_DELTA;
    rate_interval_unit = acmp_pkg::UNIT_MS;
    rate_interval_length = 16'h0001;
    step(30);
    `CHK(pickup, 1'b0)
    new_plus = 32'sh00001388;
    wait_lvl(0, 1'b1, 20, n);
    `CHK(n < 20, 1'b1)
    // a longer interval, then the seconds unit, stretch how long one change stands
    rate_interval_length = 16'h0003;
    step(30);
    new_plus = 32'sh00001b58;
    wait_lvl(0, 1'b1, 30, n);
    `CHK(n < 30, 1'b1)
    wait_lvl(0, 1'b0, 30, n);
    `CHK(n >= 9 && n <= 15, 1'b1)
    rate_interval_unit = acmp_pkg::UNIT_S;
    rate_interval_length = 16'h0001;
    new_plus = 32'sh00002328;
    wait_lvl(0, 1'b1, 4200, n);
    `CHK(n < 4200, 1'b1)
    wait_lvl(0, 1'b0, 4200, n);
    `CHK(n >= 3990 && n <= 4010, 1'b1)
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    new_plus = '0;
    new_minus = '0;
    plus_type = acmp_pkg::QTY_FREQ;
    minus_type = acmp_pkg::QTY_FREQ;
    plus_base = '0;
    minus_base = '0;
    plus_input_select = 1'b0;
    minus_input_select = 1'b0;
    sign_handling_select = acmp_pkg::SIGN_KEEP;
    compare_kind_select = acmp_pkg::CMP_LEVEL;
    compare_sense = acmp_pkg::SENSE_OVER;
    operate_threshold = '0;
    dropout_band_pct = '0;
    rate_interval_unit = acmp_pkg::UNIT_MS;
    rate_interval_length = '0;
    operate_delay = '0;
    release_delay = '0;
    step(2);
    `CHK({pickup, operate, dropout, config_fault}, 4'h2)
    reset_n = 1'b1;
    t_select();
    t_delays();
    t_signs();
    t_bases();
    t_delta();
    t_reset_mid();
    print_verdict();
  end
endmodule
